// ==== rtl/sts_defines.svh ====
// Purpose: Named constants for the system timer subsystem.
// Assumes: One 250 MHz reference clock; slower rates come from phase accumulators.
// Notes: How it works
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

`define STS_REF_HZ 64'd250000000
`define STS_LF_HZ 64'd32768
`define STS_HF_HZ 64'd48000000
`define STS_RAT_HZ 64'd4000000
`define STS_WDT_HZ 64'd1500000
`define STS_PHASE_ONE 64'h0000000100000000
`define STS_STEP(f) (32'((f) * `STS_PHASE_ONE / `STS_REF_HZ))

`define STS_RTC_W 70
`define STS_RTC_CH 3
`define STS_INC_W 32
`define STS_RAT_W 32
`define STS_RAT_SRC_W 48
`define STS_RAT_MUL_W 70
`define STS_RAT_SCALE 22'd4000000
`define STS_RAT_FRAC_LSB 32
`define STS_GPT_HALVES 8
`define STS_GPT_TIMERS 4
`define STS_HALF_W 16
`define STS_WDT_W 32

`endif

// ==== rtl/sts_pkg.sv ====
// Purpose: Types shared by the system timer subsystem.
// Assumes: Codes are one-hot.
// Notes: None.
package sts_pkg;
   typedef enum logic [3:0] {
      STS_PM_ACTIVE = 4'h1,
      STS_PM_IDLE = 4'h2,
      STS_PM_STANDBY = 4'h4,
      STS_PM_SHUTDOWN = 4'h8
   } sts_power_t;

   typedef enum logic [4:0] {
      STS_GPT_ONESHOT = 5'h01,
      STS_GPT_PERIODIC = 5'h02,
      STS_GPT_PWM = 5'h04,
      STS_GPT_EDGE_TIME = 5'h08,
      STS_GPT_EDGE_COUNT = 5'h10
   } sts_gpt_mode_t;

   typedef enum logic [2:0] {
      STS_WDT_OFF = 3'h1,
      STS_WDT_RUN = 3'h2,
      STS_WDT_WARNED = 3'h4
   } sts_wdt_state_t;
endpackage : sts_pkg

// ==== rtl/sts_rate_gen.sv ====
// Purpose: Phase-accumulator enable generator for a slower rate.
// Assumes: STEP is rate times two to the 32 over the reference rate.
// Notes: Jitter is one reference cycle; the average rate is exact to 32 bits.
`timescale 1ns/1ps
`default_nettype none
module sts_rate_gen import sts_pkg::*; #(
   parameter logic [31:0] STEP = 32'h00000001
) (
   input wire logic ref_clk,
   input wire logic reset,
   sts_tick_if.src tickOut
);
   logic [31:0] phase;
   logic carry;
   wire [32:0] next_phase = {1'b0, phase} + {1'b0, STEP};

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         phase <= 32'h00000000;
         carry <= 1'b0;
      end else begin
         phase <= next_phase[31:0];
         carry <= next_phase[32];
      end
   end

   assign tickOut.tick = carry;
endmodule : sts_rate_gen
`default_nettype wire

// ==== rtl/sts_tick_if.sv ====
// Purpose: Carries one rate-enable pulse between modules.
// Assumes: Same clock on both sides.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface sts_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : sts_tick_if
`default_nettype wire

// ==== rtl/sts_timer_subsystem.sv ====
// Purpose: Real-time counter, general-purpose timers, radio timer and watchdog.
// Assumes: All inputs synchronous to ref_clk; control arrives on plain ports.
// Notes: Event outputs are one-cycle pulses toward the event fabric.
`timescale 1ns/1ps
`default_nettype none
`include "sts_defines.svh"
module sts_timer_subsystem import sts_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire sts_power_t powerMode,
   input wire logic debugHalt,
   input wire logic rtcEnable,
   input wire logic rtcRunInDebug,
   input wire logic [`STS_INC_W-1:0] rtcIncrement,
   input wire logic [`STS_RTC_CH-1:0] rtcChannelEnable,
   input wire logic [`STS_RTC_CH-1:0][`STS_RTC_W-1:0] rtcCompare,
   output logic [`STS_RTC_W-1:0] rtcCount,
   output logic [`STS_RTC_CH-1:0] rtcEvent,
   output logic wakeRequest,
   input wire logic radioOn,
   output logic [`STS_RAT_W-1:0] radioTime,
   input wire logic [`STS_GPT_HALVES-1:0] gptEnable,
   input wire logic [`STS_GPT_TIMERS-1:0] gptSplit,
   input wire sts_gpt_mode_t [`STS_GPT_HALVES-1:0] gptMode,
   input wire logic [`STS_GPT_HALVES-1:0][`STS_HALF_W-1:0] gptLoad,
   input wire logic [`STS_GPT_HALVES-1:0][`STS_HALF_W-1:0] gptMatch,
   input wire logic [`STS_GPT_HALVES-1:0] fabricIn,
   output logic [`STS_GPT_HALVES-1:0] gptTimeout,
   output logic [`STS_GPT_HALVES-1:0] pwmOut,
   output logic [`STS_GPT_HALVES-1:0][`STS_HALF_W-1:0] gptCount,
   output logic [`STS_GPT_HALVES-1:0][`STS_HALF_W-1:0] gptCapture,
   input wire logic wdtEnable,
   input wire logic [`STS_WDT_W-1:0] wdtReload,
   input wire logic wdtKick,
   input wire logic wdtIntClear,
   input wire logic wdtResetEnable,
   output logic wdtInterrupt,
   output logic wdtResetReq
);

   // Rate enables
   sts_tick_if lfTick ();
   sts_tick_if hfTick ();
   sts_tick_if ratTick ();
   sts_tick_if wdtTick ();

   sts_rate_gen #(.STEP(`STS_STEP(`STS_LF_HZ))) lfGen (
      .ref_clk(ref_clk),
      .reset(reset),
      .tickOut(lfTick)
   );
   sts_rate_gen #(.STEP(`STS_STEP(`STS_HF_HZ))) hfGen (
      .ref_clk(ref_clk),
      .reset(reset),
      .tickOut(hfTick)
   );
   sts_rate_gen #(.STEP(`STS_STEP(`STS_RAT_HZ))) ratGen (
      .ref_clk(ref_clk),
      .reset(reset),
      .tickOut(ratTick)
   );
   sts_rate_gen #(.STEP(`STS_STEP(`STS_WDT_HZ))) wdtGen (
      .ref_clk(ref_clk),
      .reset(reset),
      .tickOut(wdtTick)
   );

   wire inShutdown = (powerMode == STS_PM_SHUTDOWN);
   wire inStandby = (powerMode == STS_PM_STANDBY);
   wire gptPowered = (powerMode == STS_PM_ACTIVE) || (powerMode == STS_PM_IDLE);

   // Real-time counter
   wire rtcStep = lfTick.tick && rtcEnable && !inShutdown
      && (!debugHalt || rtcRunInDebug);
   wire [`STS_RTC_W-1:0] next_rtcCount = rtcCount + `STS_RTC_W'(rtcIncrement);
   logic [`STS_RTC_CH-1:0] rtcHit;

   // Crossing test, since a large increment may step over the exact value
   generate
      for (genvar c = 0; c < `STS_RTC_CH; c++) begin : gRtcCh
         assign rtcHit[c] = rtcStep && rtcChannelEnable[c]
            && (rtcCount < rtcCompare[c]) && (next_rtcCount >= rtcCompare[c]);
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rtcCount <= '0;
         rtcEvent <= '0;
         wakeRequest <= 1'b0;
      end else begin
         if (rtcStep) begin
            rtcCount <= next_rtcCount;
         end
         rtcEvent <= rtcHit;
         wakeRequest <= (|rtcHit) && inStandby;
      end
   end

   // Radio timer: low 16 bits of whole seconds and fraction of the counter scaled to 4 MHz ticks
   logic radioOnPrev;
   wire radioSwitch = radioOn ^ radioOnPrev;
   wire [`STS_RAT_MUL_W-1:0] ratProduct = rtcCount[`STS_RAT_SRC_W-1:0] * `STS_RAT_SCALE;
   wire [`STS_RAT_W-1:0] ratFromRtc = ratProduct[`STS_RAT_FRAC_LSB +: `STS_RAT_W];

   // Timer is only stepped while the radio is on; each on or off change reloads it from the real-time counter
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         radioOnPrev <= 1'b0;
         radioTime <= '0;
      end else begin
         radioOnPrev <= radioOn;
         if (radioSwitch) begin
            radioTime <= ratFromRtc;
         end else if (radioOn && ratTick.tick) begin
            radioTime <= radioTime + `STS_RAT_W'(1);
         end
      end
   end

   // General-purpose timers, one half per loop pass
   logic [`STS_GPT_HALVES-1:0] fabricPrev;
   logic [`STS_GPT_HALVES-1:0] halfStep;
   logic [`STS_GPT_HALVES-1:0] halfZero;
   logic [`STS_GPT_HALVES-1:0] halfDone;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fabricPrev <= '0;
      end else begin
         fabricPrev <= fabricIn;
      end
   end

   generate
      for (genvar h = 0; h < `STS_GPT_HALVES; h++) begin : gHalf
         localparam int LO = h - (h % 2);
         localparam int PART = h ^ 1;
         localparam bit UPPER = (h % 2) == 1;
         wire joined = !gptSplit[h / 2];
         wire useLo = joined && UPPER;
         wire sts_gpt_mode_t mode = useLo ? gptMode[LO] : gptMode[h];
         wire en = useLo ? gptEnable[LO] : gptEnable[h];
         wire srcIdx = useLo;
         wire edgeSeen = srcIdx ? (fabricIn[LO] && !fabricPrev[LO])
                                : (fabricIn[h] && !fabricPrev[h]);
         wire baseTick = (mode == STS_GPT_EDGE_COUNT) ? edgeSeen : hfTick.tick;
         wire ownStep = gptPowered && en && !halfDone[h] && baseTick;
         wire wholeZero = halfZero[h] && (!joined || halfZero[PART]);
         wire wrap = halfStep[h] && wholeZero;
         wire [2*`STS_HALF_W-1:0] pairCnt = {gptCount[LO + 1], gptCount[LO]};
         wire [2*`STS_HALF_W-1:0] pairMatch = {gptMatch[LO + 1], gptMatch[LO]};
         wire pwmLevel = joined ? (!UPPER && (pairCnt < pairMatch))
                                : (gptCount[h] < gptMatch[h]);

         // Upper half of a joined pair borrows from the lower half
         assign halfStep[h] = useLo ? (halfStep[LO] && halfZero[LO]) : ownStep;
         assign halfZero[h] = (gptCount[h] == '0);

         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               gptCount[h] <= '0;
               gptCapture[h] <= '0;
               gptTimeout[h] <= 1'b0;
               pwmOut[h] <= 1'b0;
               halfDone[h] <= 1'b0;
            end else begin
               if (!en) begin
                  gptCount[h] <= gptLoad[h];
               end else if (wrap) begin
                  if (mode != STS_GPT_ONESHOT) begin
                     gptCount[h] <= gptLoad[h];
                  end
               end else if (halfStep[h]) begin
                  gptCount[h] <= gptCount[h] - `STS_HALF_W'(1);
               end
               if (!en) begin
                  halfDone[h] <= 1'b0;
               end else if (wrap && mode == STS_GPT_ONESHOT) begin
                  halfDone[h] <= 1'b1;
               end
               if (en && gptPowered && edgeSeen && mode == STS_GPT_EDGE_TIME) begin
                  gptCapture[h] <= gptCount[h];
               end
               gptTimeout[h] <= wrap && (!joined || UPPER);
               pwmOut[h] <= en && (mode == STS_GPT_PWM) && pwmLevel;
            end
         end
      end
   endgenerate

   // Watchdog
   sts_wdt_state_t wdtState;
   sts_wdt_state_t next_wdtState;
   logic [`STS_WDT_W-1:0] wdtCount;
   wire wdtCounting = wdtTick.tick && !inStandby && !inShutdown && !debugHalt;
   wire wdtExpire = wdtCounting && (wdtCount == '0) && (wdtState != STS_WDT_OFF);
   wire wdtReset = wdtExpire && (wdtState == STS_WDT_WARNED) && wdtResetEnable;

   // Enable is only looked at while off, so software cannot stop it
   always_comb begin
      next_wdtState = wdtState;
      case (wdtState)
         STS_WDT_OFF: begin
            if (wdtEnable) begin
               next_wdtState = STS_WDT_RUN;
            end
         end
         STS_WDT_RUN: begin
            if (wdtExpire) begin
               next_wdtState = STS_WDT_WARNED;
            end
         end
         STS_WDT_WARNED: begin
            // A timeout in the clearing cycle keeps the interrupt pending
            if (wdtIntClear && !wdtExpire) begin
               next_wdtState = STS_WDT_RUN;
            end
         end
         default: begin
            next_wdtState = STS_WDT_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wdtState <= STS_WDT_OFF;
         wdtCount <= '0;
         wdtResetReq <= 1'b0;
      end else begin
         wdtState <= next_wdtState;
         if (wdtState == STS_WDT_OFF || wdtKick || wdtExpire) begin
            wdtCount <= wdtReload;
         end else if (wdtCounting) begin
            wdtCount <= wdtCount - `STS_WDT_W'(1);
         end
         wdtResetReq <= wdtReset;
      end
   end

   assign wdtInterrupt = (wdtState == STS_WDT_WARNED);

endmodule : sts_timer_subsystem
`default_nettype wire

// ==== testbench/sts_fabric_model.sv ====
// Purpose: Event fabric stand-in feeding timer inputs.
// Assumes: Requests change on the falling edge.
// Notes: Registered so every edge lasts whole cycles.
`timescale 1ns/1ps
`default_nettype none
module sts_fabric_model (
   input wire logic ref_clk,
   input wire logic [7:0] fabricStrobe,
   output logic [7:0] fabricIn
);
   initial fabricIn = 8'h0;
   // Taken on the rising edge so it never races the bench's falling-edge drive
   always @(posedge ref_clk) begin
      fabricIn <= fabricStrobe;
   end
endmodule : sts_fabric_model
`default_nettype wire

// ==== testbench/sts_timer_monitor.sv ====
// Purpose: Port-level checks for the timer subsystem.
// Assumes: One clock domain; sees only top ports.
// Notes: Radio sync allows one cycle for the on-edge to be seen.
`timescale 1ns/1ps
`default_nettype none
module sts_timer_monitor import sts_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire sts_power_t powerMode,
   input wire logic debugHalt,
   input wire logic rtcRunInDebug,
   input wire logic [2:0][69:0] rtcCompare,
   input wire logic [69:0] rtcCount,
   input wire logic [2:0] rtcEvent,
   input wire logic wakeRequest,
   input wire logic radioOn,
   input wire logic [31:0] radioTime,
   input wire logic [7:0] gptEnable,
   input wire logic [7:0][15:0] gptCount,
   input wire logic wdtInterrupt,
   input wire logic wdtIntClear,
   input wire logic wdtResetEnable,
   input wire logic wdtResetReq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_RTC_SHUTDOWN: assert property (
      powerMode == STS_PM_SHUTDOWN |=> $stable(rtcCount)) else $error("rtc ran in shutdown");
   AST_RTC_DEBUG: assert property (
      debugHalt && !rtcRunInDebug |=> $stable(rtcCount)) else $error("rtc ran in halt");
   AST_RTC_EVENT: assert property (
      rtcEvent[0] |-> $past(rtcCount) < $past(rtcCompare[0]) && rtcCount >= $past(rtcCompare[0]))
      else $error("event without crossing");
   AST_WAKE: assert property (
      wakeRequest |-> rtcEvent != 3'h0 && $past(powerMode) == STS_PM_STANDBY)
      else $error("wake without standby event");
   AST_GPT_STANDBY: assert property (
      powerMode == STS_PM_STANDBY && gptEnable[0] |=> $stable(gptCount[0]))
      else $error("timer ran in standby");
   AST_WDT_STICKY: assert property (
      wdtInterrupt && !wdtIntClear |=> wdtInterrupt) else $error("irq dropped");
   AST_WDT_RESET: assert property (
      wdtResetReq |-> $past(wdtInterrupt) && $past(wdtResetEnable))
      else $error("reset without pending irq");
   AST_RADIO_SYNC: assert property (
      $rose(radioOn) |-> ##1 radioTime == 32'((70'($past(rtcCount[47:0])) * 70'd4000000) >> 32))
      else $error("radio not synced");
endmodule : sts_timer_monitor
bind sts_timer_subsystem sts_timer_monitor u_sts_timer_monitor (.ref_clk, .reset, .powerMode,
   .debugHalt, .rtcRunInDebug, .rtcCompare, .rtcCount, .rtcEvent, .wakeRequest, .radioOn,
   .radioTime, .gptEnable, .gptCount, .wdtInterrupt, .wdtIntClear, .wdtResetEnable, .wdtResetReq);
`default_nettype wire

// ==== testbench/test_sts_timer_subsystem.sv ====
// Purpose: Self-checking bench for the timer subsystem.
// Assumes: Inputs change on the falling edge.
// Notes: RTC waits span one low-frequency tick each.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
`define WAITF(c, n) begin for (int k = 0; k < (n) && !(c); k++) @(negedge ref_clk); \
   if (!(c)) begin n_fail++; conclude(); end end
module test_sts_timer_subsystem import sts_pkg::*; ;
   sts_power_t powerMode = STS_PM_ACTIVE;
   sts_gpt_mode_t [7:0] gptMode;
   logic ref_clk = 1'b0, reset = 1'b1, debugHalt = 1'b0, rtcEnable = 1'b0, rtcRunInDebug = 1'b0;
   logic radioOn = 1'b0, wdtEnable = 1'b0, wdtKick = 1'b0, wdtIntClear = 1'b0;
   logic wdtResetEnable = 1'b0, wakeRequest, wdtInterrupt, wdtResetReq;
   logic [31:0] rtcIncrement = 32'h0, wdtReload = 32'h0, radioTime;
   logic [2:0] rtcChannelEnable = 3'h0, rtcEvent;
   logic [2:0][69:0] rtcCompare = '0;
   logic [69:0] rtcCount, hold;
   logic [7:0] gptEnable = 8'h0, fabricStrobe = 8'h0, fabricIn, gptTimeout, pwmOut;
   logic [3:0] gptSplit = 4'hf;
   logic [7:0][15:0] gptLoad = '0, gptMatch = '0, gptCount, gptCapture;
   int n_fail = 0, tests_run = 0;
   sts_timer_subsystem u_sts_timer_subsystem (.ref_clk, .reset, .powerMode, .debugHalt,
      .rtcEnable, .rtcRunInDebug, .rtcIncrement, .rtcChannelEnable, .rtcCompare, .rtcCount,
      .rtcEvent, .wakeRequest, .radioOn, .radioTime, .gptEnable, .gptSplit, .gptMode, .gptLoad,
      .gptMatch, .fabricIn, .gptTimeout, .pwmOut, .gptCount, .gptCapture, .wdtEnable, .wdtReload,
      .wdtKick, .wdtIntClear, .wdtResetEnable, .wdtInterrupt, .wdtResetReq);
   sts_fabric_model u_sts_fabric_model (.ref_clk, .fabricStrobe, .fabricIn);
   always #2 ref_clk = ~ref_clk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic gpt_check;
      gptLoad[0] = 16'h2;
      gptLoad[1] = 16'h3;
      gptLoad[3] = 16'h1;
      gptMode[1] = STS_GPT_EDGE_COUNT;
      gptSplit = 4'hd;
      // One cycle disabled so every half preloads before it counts
      @(negedge ref_clk);
      gptEnable = 8'h07;
      `WAITF(gptTimeout[0] === 1'b1, 200)
      `CHK("reload", 16'h2, gptCount[0])
      `CHK("joinedUpper", 16'h0, gptCount[3])
      `CHK("joinedLower", 16'hfffd, gptCount[2])
      repeat (3) begin
         fabricStrobe = 8'h02;
         repeat (2) @(negedge ref_clk);
         fabricStrobe = 8'h0;
         repeat (2) @(negedge ref_clk);
      end
      `CHK("edgeCount", 16'h0, gptCount[1])
      powerMode = STS_PM_STANDBY;
      @(negedge ref_clk);
      hold = 70'(gptCount[0]);
      repeat (100) @(negedge ref_clk);
      `CHK("standbyCount", hold, 70'(gptCount[0]))
   endtask : gpt_check
   task automatic wdt_check;
      powerMode = STS_PM_ACTIVE;
      wdtReload = 32'h1;
      wdtResetEnable = 1'b1;
      wdtEnable = 1'b1;
      @(negedge ref_clk);
      wdtEnable = 1'b0;
      `WAITF(wdtInterrupt === 1'b1, 1000)
      `CHK("earlyReset", 1'b0, wdtResetReq)
      `WAITF(wdtResetReq === 1'b1, 1000)
      `CHK("irqHeld", 1'b1, wdtInterrupt)
      wdtIntClear = 1'b1;
      @(negedge ref_clk);
      wdtIntClear = 1'b0;
      `CHK("irqCleared", 1'b0, wdtInterrupt)
      repeat (4) begin
         wdtKick = 1'b1;
         @(negedge ref_clk);
         wdtKick = 1'b0;
         repeat (99) @(negedge ref_clk);
      end
      `CHK("kicked", 1'b0, wdtInterrupt)
   endtask : wdt_check
   task automatic gpt_modes_check;
      gptMode[4] = STS_GPT_ONESHOT;
      gptMode[5] = STS_GPT_PWM;
      gptMode[6] = STS_GPT_EDGE_TIME;
      gptLoad[4] = 16'h2;
      gptLoad[5] = 16'h3;
      gptMatch[5] = 16'h2;
      gptLoad[6] = 16'hff;
      @(negedge ref_clk);
      gptEnable = 8'h77;
      `WAITF(gptTimeout[4] === 1'b1, 50)
      `CHK("oneShotZero", 16'h0, gptCount[4])
      repeat (20) @(negedge ref_clk);
      `CHK("oneShotHold", 16'h0, gptCount[4])
      `WAITF(gptCount[5] === 16'h1, 50)
      @(negedge ref_clk);
      `CHK("pwmHigh", 1'b1, pwmOut[5])
      `WAITF(gptCount[5] === 16'h3, 50)
      @(negedge ref_clk);
      `CHK("pwmLow", 1'b0, pwmOut[5])
      fabricStrobe = 8'h40;
      @(negedge ref_clk);
      hold = 70'(gptCount[6]);
      @(negedge ref_clk);
      `CHK("capture", hold, 70'(gptCapture[6]))
      fabricStrobe = 8'h0;
   endtask : gpt_modes_check
   task automatic rtc_check;
      rtcIncrement = 32'h00020000;
      rtcCompare[0] = 70'h20000;
      rtcChannelEnable = 3'h1;
      powerMode = STS_PM_STANDBY;
      rtcEnable = 1'b1;
      `WAITF(rtcEvent[0] === 1'b1, 9000)
      `CHK("rtcStep", 70'h20000, rtcCount)
      `CHK("wake", 1'b1, wakeRequest)
      debugHalt = 1'b1;
      repeat (8000) @(negedge ref_clk);
      `CHK("rtcHalted", 70'h20000, rtcCount)
      rtcRunInDebug = 1'b1;
      `WAITF(rtcCount === 70'h40000, 8000)
      powerMode = STS_PM_SHUTDOWN;
      repeat (8000) @(negedge ref_clk);
      `CHK("rtcShutdown", 70'h40000, rtcCount)
      powerMode = STS_PM_ACTIVE;
      debugHalt = 1'b0;
      rtcEnable = 1'b0;
   endtask : rtc_check
   task automatic radio_check;
      radioOn = 1'b1;
      // Looked at before the next rate tick can move it
      @(negedge ref_clk);
      `CHK("syncOn", 32'hf4, radioTime)
      repeat (300) @(negedge ref_clk);
      `CHK("radioRuns", 1'b1, radioTime > 32'hf4)
      radioOn = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("syncOff", 32'hf4, radioTime)
   endtask : radio_check
   task automatic reset_check;
      `WAITF(wdtInterrupt === 1'b1, 400)
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      repeat (400) @(negedge ref_clk);
      `CHK("wdtAfterReset", 1'b0, wdtInterrupt)
   endtask : reset_check
   initial begin
      foreach (gptMode[i]) gptMode[i] = STS_GPT_PERIODIC;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      gpt_check();
      wdt_check();
      gpt_modes_check();
      rtc_check();
      radio_check();
      reset_check();
      conclude();
   end
endmodule : test_sts_timer_subsystem
`default_nettype wire
